//--- logic/dpf_status_bank.v
// Fault status register bank with debug unlock key
// Function
// R1: Switches nine to sixteen fail bits at 0x054E
// R2: Switches one to eight fail bits at 0x054F
// R3: Abort bit set on abort, cleared on completion
// R4: Filter diagnostic fail in bit 0, rest zero; the code reads the abort bit in bit 1
// R5: Open ground and reference pins, bits 7-5
// R6: Regulator and oscillation faults, bits 4-0
// R7: Host ignores and clears spurious oscillation flag
// R8: Second supply register faults, reserved bits zero
// R9: Analog undervoltage reset flag in bit 0
// R10: Only unlock code write activates debug
// R11: Writes ignored; flags sticky, zero after reset
`timescale 1ns/100ps
`include "dpf_consts.vh"

module dpf_status_bank (
    input wire clock,
    input wire rst_n,
    // Register port
    input wire [`DPF_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_reg,
    // Diagnostic results, one-cycle set pulses
    input wire [15:0] switch_fail_set,
    input wire filter_diag_fail_set,
    input wire cmp_diag_abort,
    input wire cmp_diag_done,
    input wire [7:0] supply_a_set,
    input wire [7:0] supply_b_set,
    // Reset cause level, caught after release
    input wire uv_reset_cause,
    // Fault-clear mechanism
    input wire clr_req,
    input wire [2:0] clr_sel,
    input wire [7:0] clr_mask,
    // Outputs
    output wire irq,
    output reg debug_active_reg
);

// ----------------------------------------
// Address decoder
// ----------------------------------------
// Shared by read mux and write decode
function [3:0] reg_index;
    input [`DPF_ADDR_W-1:0] addr;
    begin
        case (addr)
            `DPF_OFS_SW_HI: reg_index = `DPF_IDX_SW_HI;
            `DPF_OFS_SW_LO: reg_index = `DPF_IDX_SW_LO;
            `DPF_OFS_CMP_MISC: reg_index = `DPF_IDX_CMP_MISC;
            `DPF_OFS_PWR_A: reg_index = `DPF_IDX_PWR_A;
            `DPF_OFS_PWR_B: reg_index = `DPF_IDX_PWR_B;
            `DPF_OFS_PWR_C: reg_index = `DPF_IDX_PWR_C;
            `DPF_OFS_DBG_KEY: reg_index = `DPF_IDX_DBG_KEY;
            `DPF_OFS_INT_STAT: reg_index = `DPF_IDX_INT_STAT;
            `DPF_OFS_INT_MASK: reg_index = `DPF_IDX_INT_MASK;
            default: reg_index = `DPF_IDX_NONE;
        endcase
    end
endfunction

// Index of the current access
wire [3:0] wr_idx;
wire [3:0] rd_idx;
assign wr_idx = reg_index(reg_addr);
assign rd_idx = wr_idx;

// ----------------------------------------
// Set vectors for the six status registers
// ----------------------------------------
// Register k uses bits [8k+7:8k]
wire [47:0] set_bus;
wire [47:0] valid_bus;
wire [47:0] clr_bus;
wire [47:0] flag_bus;
reg first_cycle_reg; // High in first cycle after reset
reg uv_flag_set; // Reset cause capture pulse

// Upper switches to the high register
// [R1]
assign set_bus[7:0] = switch_fail_set[15:8];
// Lower switches to the low register
// [R2]
assign set_bus[15:8] = switch_fail_set[7:0];
// Only the filter bit is sticky here
// [R4]
assign set_bus[23:16] = {7'h00, filter_diag_fail_set};
// Ground, reference and regulator faults
// [R5] [R6]
assign set_bus[31:24] = supply_a_set;
// Reserved bits masked below
// [R8]
assign set_bus[39:32] = supply_b_set;
// Undervoltage reset flag
// [R9]
assign set_bus[47:40] = {7'h00, uv_flag_set};

// Reserved bits never store a one
assign valid_bus = {`DPF_VALID_PWR_C, `DPF_VALID_PWR_B,
                    `DPF_VALID_PWR_A, `DPF_VALID_MISC,
                    `DPF_VALID_SW, `DPF_VALID_SW};

// ----------------------------------------
// Sticky flag groups
// ----------------------------------------
// Bus writes never reach these; only clr_* does
genvar k;
generate
    for (k = 0; k < `DPF_NUM_STAT; k = k + 1) begin : g_stat
        // Clear targets one register at a time
        assign clr_bus[8*k+7:8*k] =
            (clr_req && clr_sel == k) ? clr_mask : 8'h00; // [R11]
        dpf_sticky_bits #(
            .W(8)
        ) u_flags (
            .clock(clock),
            .rst_n(rst_n),
            .set_bits(set_bus[8*k+7:8*k] & valid_bus[8*k+7:8*k]),
            .clr_bits(clr_bus[8*k+7:8*k]),
            .q_reg(flag_bus[8*k+7:8*k])
        );
    end
endgenerate

// ----------------------------------------
// Reset cause capture
// ----------------------------------------
// The cause is a level; catch it once after release
// rather than loading a port under async reset.
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        first_cycle_reg <= 1'b1;
    end else begin
        first_cycle_reg <= 1'b0;
    end
end

// Pulse into the sticky flag in the first cycle
always @* begin
    uv_flag_set = first_cycle_reg & uv_reset_cause; // [R9]
end

// ----------------------------------------
// Comparison abort bit
// ----------------------------------------
// Tracks the latest outcome, not sticky.
// Abort wins if both arrive together.
reg abort_reg;
reg abort_next;
wire abort_clr;
assign abort_clr = clr_req && (clr_sel == 3'h2)
                   && clr_mask[`DPF_BIT_ADC_ABORT];

// Next abort state
always @* begin
    abort_next = abort_reg;
    if (abort_clr) begin
        abort_next = 1'b0;
    end
    if (cmp_diag_done) begin
        abort_next = 1'b0; // [R3]
    end
    if (cmp_diag_abort) begin
        abort_next = 1'b1; // [R3]
    end
end

// Abort storage
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        abort_reg <= 1'b0;
    end else begin
        abort_reg <= abort_next;
    end
end

// ----------------------------------------
// Register views
// ----------------------------------------
wire [7:0] view_sw_hi;
wire [7:0] view_sw_lo;
wire [7:0] view_misc;
wire [7:0] view_pwr_a;
wire [7:0] view_pwr_b;
wire [7:0] view_pwr_c;
assign view_sw_hi = flag_bus[7:0]; // [R1]
assign view_sw_lo = flag_bus[15:8]; // [R2]
// Bits 7..2 read zero
assign view_misc = {6'h00, abort_reg,
                    flag_bus[16 + `DPF_BIT_FILTER_FAIL]}; // [R3] [R4]
// Spurious oscillation flag: host clears it
assign view_pwr_a = flag_bus[31:24]; // [R5] [R6] [R7]
assign view_pwr_b = flag_bus[39:32]; // [R8]
assign view_pwr_c = flag_bus[47:40]; // [R9]

// ----------------------------------------
// Debug unlock key
// ----------------------------------------
reg [7:0] key_reg; // Last written code
wire key_wr;
assign key_wr = reg_wr && (wr_idx == `DPF_IDX_DBG_KEY);

// Any other value deactivates debug
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        key_reg <= `DPF_KEY_RST;
        debug_active_reg <= 1'b0;
    end else if (key_wr) begin
        key_reg <= reg_wdata;
        debug_active_reg <= (reg_wdata == `DPF_UNLOCK_CODE); // [R10]
    end
end

// ----------------------------------------
// Interrupt events
// ----------------------------------------
// One event per register on a newly raised flag
wire [`DPF_INT_W-1:0] int_events;
wire [`DPF_INT_W-1:0] int_stat;
wire [`DPF_INT_W-1:0] int_mask;
genvar e;
generate
    for (e = 0; e < `DPF_NUM_STAT; e = e + 1) begin : g_evt
        assign int_events[e] = |(set_bus[8*e+7:8*e]
            & valid_bus[8*e+7:8*e] & ~flag_bus[8*e+7:8*e]);
    end
endgenerate
// Debug turned on by a matching code write
assign int_events[`DPF_BIT_INT_DEBUG] =
    key_wr && (reg_wdata == `DPF_UNLOCK_CODE) && !debug_active_reg;

// Status, mask and level interrupt
dpf_irq_ctrl u_irq (
    .clock(clock),
    .rst_n(rst_n),
    .events(int_events),
    .stat_wr(reg_wr && (wr_idx == `DPF_IDX_INT_STAT)),
    .mask_wr(reg_wr && (wr_idx == `DPF_IDX_INT_MASK)),
    .wdata(reg_wdata[`DPF_INT_W-1:0]),
    .stat_reg(int_stat),
    .mask_reg(int_mask),
    .irq_reg(irq)
);

// ----------------------------------------
// Read data
// ----------------------------------------
reg [7:0] rdata_next; // Mux result

// Unmapped addresses read zero
always @* begin
    rdata_next = 8'h00;
    if (reg_rd) begin
        case (rd_idx)
            `DPF_IDX_SW_HI: rdata_next = view_sw_hi;
            `DPF_IDX_SW_LO: rdata_next = view_sw_lo;
            `DPF_IDX_CMP_MISC: rdata_next = view_misc;
            `DPF_IDX_PWR_A: rdata_next = view_pwr_a;
            `DPF_IDX_PWR_B: rdata_next = view_pwr_b;
            `DPF_IDX_PWR_C: rdata_next = view_pwr_c;
            `DPF_IDX_DBG_KEY: rdata_next = key_reg;
            `DPF_IDX_INT_STAT: rdata_next = {1'b0, int_stat};
            `DPF_IDX_INT_MASK: rdata_next = {1'b0, int_mask};
            default: rdata_next = 8'h00;
        endcase
    end
end

// Data stands only in the cycle after the read
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        reg_rdata_reg <= 8'h00;
    end else begin
        reg_rdata_reg <= rdata_next;
    end
end

endmodule // dpf_status_bank

//--- logic/dpf_consts.vh
// Constants for the diagnostic and power fault status bank
`ifndef DPF_CONSTS_VH
`define DPF_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DPF_ADDR_W 12
`define DPF_OFS_SW_HI 12'h54E
`define DPF_OFS_SW_LO 12'h54F
`define DPF_OFS_CMP_MISC 12'h550
`define DPF_OFS_PWR_A 12'h552
`define DPF_OFS_PWR_B 12'h553
`define DPF_OFS_PWR_C 12'h554
`define DPF_OFS_DBG_KEY 12'h700
`define DPF_OFS_INT_STAT 12'h7F0
`define DPF_OFS_INT_MASK 12'h7F1

// ----------------------------------------
// Register index codes from the decoder
// ----------------------------------------
`define DPF_IDX_SW_HI 4'h0
`define DPF_IDX_SW_LO 4'h1
`define DPF_IDX_CMP_MISC 4'h2
`define DPF_IDX_PWR_A 4'h3
`define DPF_IDX_PWR_B 4'h4
`define DPF_IDX_PWR_C 4'h5
`define DPF_IDX_DBG_KEY 4'h6
`define DPF_IDX_INT_STAT 4'h7
`define DPF_IDX_INT_MASK 4'h8
`define DPF_IDX_NONE 4'hF

// ----------------------------------------
// Implemented bits per status register
// ----------------------------------------
`define DPF_VALID_SW 8'hFF
`define DPF_VALID_MISC 8'h03
`define DPF_VALID_PWR_A 8'hFF
`define DPF_VALID_PWR_B 8'h5F
`define DPF_VALID_PWR_C 8'h01

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DPF_BIT_FILTER_FAIL 0
`define DPF_BIT_ADC_ABORT 1
`define DPF_BIT_ANALOG_OSC 1
`define DPF_BIT_UV_RESET 0
`define DPF_BIT_INT_DEBUG 6

// ----------------------------------------
// Reset values and widths
// ----------------------------------------
`define DPF_STATUS_RST 8'h00
`define DPF_KEY_RST 8'h00
`define DPF_INT_RST 7'h00
`define DPF_INT_W 7
`define DPF_NUM_STAT 6
// Unlock code: arbitrary value
`define DPF_UNLOCK_CODE 8'hA5

`endif

//--- logic/dpf_sticky_bits.v
// Sticky flag group: set wins over clear
`timescale 1ns/100ps

module dpf_sticky_bits #(
    parameter W = 8
) (
    input wire clock,
    input wire rst_n,
    input wire [W-1:0] set_bits,
    input wire [W-1:0] clr_bits,
    output reg [W-1:0] q_reg
);

// ----------------------------------------
// Flag storage
// ----------------------------------------
wire [W-1:0] q_next; // Set overrides a same-cycle clear
assign q_next = (q_reg & ~clr_bits) | set_bits;

// Flags are zero after reset
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        q_reg <= {W{1'b0}};
    end else begin
        q_reg <= q_next;
    end
end

endmodule // dpf_sticky_bits

//--- logic/dpf_irq_ctrl.v
// Interrupt status, mask and level output
`timescale 1ns/100ps
`include "dpf_consts.vh"

module dpf_irq_ctrl (
    input wire clock,
    input wire rst_n,
    input wire [`DPF_INT_W-1:0] events,
    input wire stat_wr,
    input wire mask_wr,
    input wire [`DPF_INT_W-1:0] wdata,
    output reg [`DPF_INT_W-1:0] stat_reg,
    output reg [`DPF_INT_W-1:0] mask_reg,
    output reg irq_reg
);

// ----------------------------------------
// Next values
// ----------------------------------------
reg [`DPF_INT_W-1:0] stat_next; // Sticky events
reg [`DPF_INT_W-1:0] mask_next; // Enable bits

// Write one to clear; a new event wins
always @* begin
    stat_next = stat_reg;
    if (stat_wr) begin
        stat_next = stat_next & ~wdata;
    end
    stat_next = stat_next | events;
    mask_next = mask_wr ? wdata : mask_reg;
end

// ----------------------------------------
// State
// ----------------------------------------
// Irq is a flop fed from next status and mask, so it changes in the same cycle as status
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        stat_reg <= `DPF_INT_RST;
        mask_reg <= `DPF_INT_RST;
        irq_reg <= 1'b0;
    end else begin
        stat_reg <= stat_next;
        mask_reg <= mask_next;
        irq_reg <= |(stat_next & mask_next);
    end
end

endmodule // dpf_irq_ctrl

//--- tb/dpf_status_bank_properties.sv
// Checker for the fault status bank ports
`timescale 1ns/100ps
`include "dpf_consts.vh"

module dpf_status_bank_properties (
    input wire clock,
    input wire rst_n,
    input wire [`DPF_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_reg,
    input wire cmp_diag_abort,
    input wire cmp_diag_done,
    input wire debug_active_reg
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Key register write and misc status read
    wire key_wr = reg_wr && reg_addr == `DPF_OFS_DBG_KEY;
    wire rd_misc = reg_rd && reg_addr == `DPF_OFS_CMP_MISC;
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_rdata_idle_zero:
        assert property (!reg_rd |=> reg_rdata_reg == 8'h00)
        else $error("read data not zero outside a read");
    a_misc_reserved_zero:
        assert property (rd_misc |=> reg_rdata_reg[7:2] == 6'h00)
        else $error("misc reserved bits set");
    a_pwr_b_reserved:
        assert property (reg_rd && reg_addr == `DPF_OFS_PWR_B
            |=> !reg_rdata_reg[7] && !reg_rdata_reg[5])
        else $error("supply b reserved bits set");
    a_pwr_c_reserved:
        assert property (reg_rd && reg_addr == `DPF_OFS_PWR_C
            |=> reg_rdata_reg[7:1] == 7'h00)
        else $error("supply c reserved bits set");
    a_abort_shown:
        assert property (cmp_diag_abort ##1 rd_misc |=> reg_rdata_reg[1])
        else $error("abort not shown");
    a_done_clears_abort:
        assert property (cmp_diag_done && !cmp_diag_abort ##1 rd_misc
            |=> !reg_rdata_reg[1])
        else $error("completion left abort set");
    a_unlock_opens:
        assert property (key_wr && reg_wdata == `DPF_UNLOCK_CODE
            |=> debug_active_reg)
        else $error("unlock code ignored");
    a_wrong_code_locks:
        assert property (key_wr && reg_wdata != `DPF_UNLOCK_CODE
            |=> !debug_active_reg)
        else $error("wrong code left debug active");
    a_debug_only_on_key:
        assert property (!key_wr |=> $stable(debug_active_reg))
        else $error("debug changed without key write");
endmodule // dpf_status_bank_properties

bind dpf_status_bank dpf_status_bank_properties i_chk (.clock, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_reg,
    .cmp_diag_abort, .cmp_diag_done, .debug_active_reg);

//--- tb/test_dpf_status_bank.sv
// Self-checking bench for the fault status bank
`timescale 1ns/100ps
`include "dpf_consts.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    n_fail++; $display("mismatch %s exp %h got %h", n, e, g); end end

module test_dpf_status_bank;
    logic clock = 0;
    logic rst_n = 0;
    logic [11:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic [15:0] sw_set = 0;
    logic filt = 0;
    logic abrt = 0;
    logic done = 0;
    logic [7:0] a_set = 0;
    logic [7:0] b_set = 0;
    logic uv = 0;
    logic clr_req = 0;
    logic [2:0] clr_sel = 0;
    logic [7:0] clr_mask = 0;
    wire [7:0] reg_rdata_reg;
    wire irq;
    wire debug_active_reg;
    int n_fail = 0;
    int checks_done = 0;

    // 50 MHz clock
    always #10 clock = ~clock;

    dpf_status_bank i_dut (.clock(clock), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg),
        .switch_fail_set(sw_set), .filter_diag_fail_set(filt),
        .cmp_diag_abort(abrt), .cmp_diag_done(done),
        .supply_a_set(a_set), .supply_b_set(b_set),
        .uv_reset_cause(uv), .clr_req(clr_req), .clr_sel(clr_sel),
        .clr_mask(clr_mask), .irq(irq),
        .debug_active_reg(debug_active_reg));

    // ----------------------------------------
    // Bus and stimulus tasks, entered at an edge
    // ----------------------------------------
    // An idle edge follows, so back-to-back calls never
    // assign the strobe twice in one time step
    task wr(input [11:0] a, input [7:0] d);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 0;
        @(posedge clock);
    endtask

    // Data stands only in the cycle after the strobe
    task rd(input [11:0] a, input [7:0] e);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 0;
        @(negedge clock);
        `CHK("rdata", e, reg_rdata_reg)
        @(posedge clock);
    endtask

    // One-cycle set pulses; m is filter, abort, done
    task pulse(input [15:0] s, input [7:0] a, input [7:0] b,
        input [2:0] m);
        {sw_set, a_set, b_set, filt, abrt, done} <= {s, a, b, m};
        @(posedge clock);
        {sw_set, a_set, b_set, filt, abrt, done} <= '0;
    endtask

    task clr(input [2:0] s, input [7:0] k);
        clr_req <= 1;
        clr_sel <= s;
        clr_mask <= k;
        @(posedge clock);
        clr_req <= 0;
    endtask

    // Levels are given one cycle to follow their cause
    task sees(input logic ei, input logic ed);
        @(posedge clock);
        @(negedge clock);
        `CHK("irq", ei, irq)
        `CHK("debug", ed, debug_active_reg)
        @(posedge clock);
    endtask

    task do_reset(input logic u);
        uv <= u;
        rst_n <= 0;
        repeat (4) @(posedge clock);
        rst_n <= 1;
        @(posedge clock);
        uv <= 0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_switch;
        pulse(16'h8001, 0, 0, 0);
        rd(`DPF_OFS_SW_HI, 8'h80);
        rd(`DPF_OFS_SW_LO, 8'h01);
        pulse(16'h0100, 0, 0, 0);
        wr(`DPF_OFS_SW_HI, 8'h00);
        rd(`DPF_OFS_SW_HI, 8'h81);
    endtask

    // Abort then completion, then both at once
    task t_misc;
        pulse(0, 0, 0, 3'b110);
        rd(`DPF_OFS_CMP_MISC, 8'h03);
        pulse(0, 0, 0, 3'b001);
        rd(`DPF_OFS_CMP_MISC, 8'h01);
        pulse(0, 0, 0, 3'b011);
        rd(`DPF_OFS_CMP_MISC, 8'h03);
        clr(2, 8'h02);
        rd(`DPF_OFS_CMP_MISC, 8'h01);
    endtask

    task t_supply;
        pulse(0, 8'hFF, 8'hFF, 0);
        rd(`DPF_OFS_PWR_A, 8'hFF);
        rd(`DPF_OFS_PWR_B, 8'h5F);
        rd(`DPF_OFS_PWR_C, 8'h00);
        clr(3, 8'h02);
        rd(`DPF_OFS_PWR_A, 8'hFD);
    endtask

    // Spurious oscillation flag: cleared, then raised again
    task t_irq;
        wr(`DPF_OFS_INT_MASK, 8'h7F);
        rd(`DPF_OFS_INT_STAT, 8'h1F);
        sees(1, 0);
        wr(`DPF_OFS_INT_STAT, 8'h1F);
        sees(0, 0);
        pulse(0, 8'h02, 0, 0);
        rd(`DPF_OFS_INT_STAT, 8'h08);
        sees(1, 0);
        wr(`DPF_OFS_INT_STAT, 8'h08);
        wr(`DPF_OFS_INT_MASK, 8'h40);
    endtask

    task t_key;
        wr(`DPF_OFS_DBG_KEY, `DPF_UNLOCK_CODE);
        sees(1, 1);
        rd(`DPF_OFS_DBG_KEY, `DPF_UNLOCK_CODE);
        wr(`DPF_OFS_DBG_KEY, 8'h3C);
        sees(1, 0);
        rd(12'h600, 8'h00);
    endtask

    task t_uv;
        do_reset(1);
        rd(`DPF_OFS_PWR_C, 8'h01);
        rd(`DPF_OFS_PWR_A, 8'h00);
        sees(0, 0);
    endtask

    // ----------------------------------------
    // Verdict and main sequence
    // ----------------------------------------
    task tally_and_finish;
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        do_reset(0);
        for (int i = 0; i < 7; i++) begin
            rd(`DPF_OFS_SW_HI + 12'(i), 8'h00);
        end
        t_switch;
        t_misc;
        t_supply;
        t_irq;
        t_key;
        t_uv;
        tally_and_finish;
    end

    // Run needs well under 200 cycles
    initial begin
        #20000;
        n_fail++;
        tally_and_finish;
    end
endmodule // test_dpf_status_bank
